// ---- logic/txsel_pkg.sv ----
package txsel_pkg;
  // Register map
  localparam logic [3:0] TXSEL_ADDR_SOURCE_SELECT = 4'h0;
  localparam logic [3:0] TXSEL_ADDR_CARRIER_CTRL = 4'h1;
  localparam logic [3:0] TXSEL_ADDR_TEST_SELECT = 4'h2;
  // Source select fields
  localparam int TXSEL_EXT_MOD_LSB = 6;
  localparam int TXSEL_DRV_LSB = 4;
  localparam int TXSEL_AUX_LSB = 0;
  localparam logic [7:0] TXSEL_SOURCE_SELECT_RST = 8'h10;
  // Carrier control fields
  localparam int TXSEL_INV_B_ON_BIT = 7;
  localparam int TXSEL_INV_A_ON_BIT = 6;
  localparam int TXSEL_INV_B_OFF_BIT = 5;
  localparam int TXSEL_INV_A_OFF_BIT = 4;
  localparam int TXSEL_EN_B_BIT = 1;
  localparam int TXSEL_EN_A_BIT = 0;
  localparam logic [7:0] TXSEL_CARRIER_CTRL_RST = 8'h80;
  // Test select fields
  localparam int TXSEL_TBUS_PICK_LSB = 0;
  localparam int TXSEL_EXT_TEST_LSB = 3;
  localparam logic [7:0] TXSEL_TEST_SELECT_RST = 8'h00;

  typedef enum logic [1:0] {
    TXSEL_DRV_TRI = 2'b00,
    TXSEL_DRV_CODER = 2'b01,
    TXSEL_DRV_EXT_ENV = 2'b10,
    TXSEL_DRV_HIGH = 2'b11
  } txsel_drv_t;

  typedef enum logic [3:0] {
    TXSEL_AUX_TRI = 4'b0000,
    TXSEL_AUX_LOW = 4'b0001,
    TXSEL_AUX_HIGH = 4'b0010,
    TXSEL_AUX_TBUS = 4'b0011,
    TXSEL_AUX_CODER = 4'b0100,
    TXSEL_AUX_TX_STREAM = 4'b0101,
    TXSEL_AUX_CARD_MOD = 4'b0110,
    TXSEL_AUX_RX_STREAM = 4'b0111,
    TXSEL_AUX_F_RX = 4'b1000,
    TXSEL_AUX_F_TX = 4'b1001,
    TXSEL_AUX_F_COMP = 4'b1010,
    TXSEL_AUX_F_RSVD = 4'b1011,
    TXSEL_AUX_A_RX_CAR = 4'b1100,
    TXSEL_AUX_A_TX_CAR = 4'b1101,
    TXSEL_AUX_A_RX_RAW = 4'b1110,
    TXSEL_AUX_A_ENV_RAW = 4'b1111
  } txsel_aux_t;
endpackage

// ---- logic/txsel_drive_pin.sv ----
`timescale 1ns/1ps
`default_nettype none
// One antenna output: source pick and inversion
module txsel_drive_pin
  import txsel_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] source_sel,
  input wire logic coder_env,
  input wire logic ext_env,
  input wire logic carrier_en,
  input wire logic inv_on,
  input wire logic inv_off,
  output logic pin_out,
  output logic pin_oe
);
  logic level;
  logic invert;
  logic out_ff;
  logic oe_ff;

  assign invert = carrier_en ? inv_on : inv_off; // R14

  always_comb begin
    case (source_sel)
      TXSEL_DRV_TRI: level = 1'b0;
      TXSEL_DRV_CODER: level = coder_env;
      TXSEL_DRV_EXT_ENV: level = ext_env;
      TXSEL_DRV_HIGH: level = 1'b1; // R3
      default: level = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      out_ff <= level ^ invert; // R2 R3 R14
      oe_ff <= (source_sel != TXSEL_DRV_TRI); // R2
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
endmodule
`default_nettype wire

// ---- logic/txsel_aux_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
// Auxiliary output source mux
module txsel_aux_mux
  import txsel_pkg::*;
#(
  parameter int TBUS_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] source_sel,
  input wire logic [TBUS_W-1:0] test_bus,
  input wire logic [2:0] test_bus_bit_pick,
  input wire logic coder_env,
  input wire logic tx_stream,
  input wire logic card_mod,
  input wire logic rx_stream,
  input wire logic f_rx,
  input wire logic f_tx,
  input wire logic f_comp,
  input wire logic a_rx_car,
  input wire logic a_tx_car,
  input wire logic a_rx_raw,
  input wire logic a_env_raw,
  output logic pin_out,
  output logic pin_oe
);
  logic level;
  logic drive;
  logic out_ff;
  logic oe_ff;

  always_comb begin
    drive = 1'b1;
    level = 1'b0;
    case (source_sel)
      TXSEL_AUX_TRI: drive = 1'b0; // R4
      TXSEL_AUX_LOW: level = 1'b0; // R4
      TXSEL_AUX_HIGH: level = 1'b1; // R4
      TXSEL_AUX_TBUS: level = test_bus[test_bus_bit_pick]; // R5
      TXSEL_AUX_CODER: level = coder_env; // R6
      TXSEL_AUX_TX_STREAM: level = tx_stream; // R6
      TXSEL_AUX_CARD_MOD: level = card_mod; // R7
      TXSEL_AUX_RX_STREAM: level = rx_stream; // R10
      TXSEL_AUX_F_RX: level = f_rx; // R12
      TXSEL_AUX_F_TX: level = f_tx; // R12
      TXSEL_AUX_F_COMP: level = f_comp; // R12
      TXSEL_AUX_F_RSVD: level = 1'b0; // R12
      TXSEL_AUX_A_RX_CAR: level = a_rx_car; // R13
      TXSEL_AUX_A_TX_CAR: level = a_tx_car; // R13
      TXSEL_AUX_A_RX_RAW: level = a_rx_raw; // R13
      TXSEL_AUX_A_ENV_RAW: level = a_env_raw; // R13
      default: drive = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      out_ff <= level;
      oe_ff <= drive;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
endmodule
`default_nettype wire

// ---- logic/txsel_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Bits 7:6 pick modulator pin: tristate, coder, external envelope, test.
// R2: Bits 5:4 pick both antenna outputs: tristate, coder, envelope, high.
// R3: Constant high on antennas follows each output's inversion bits.
// R4: Aux codes 0000/0001/0010 give tristate, low, high.
// R5: Aux code 0011 outputs the picked test-bus bit.
// R6: Aux 0100 coder envelope, 0101 transmit serial stream.
// R7: Aux 0110 outputs regenerated delayed card modulation.
// R8: Software must hold receive mode for receiver-derived outputs.
// R9: Software avoids code 0110 in type-A mode.
// R10: Aux 0111 outputs received serial stream.
// R11: Software avoids code 0111 in type-A mode.
// R12: Aux 1000 rx, 1001 tx, 1010 comparator; 1011 reserved.
// R13: Aux 1100-1111 type-A carrier and unfiltered receive signals.
// R14: Invert output by on-bit when carrier enabled, else off-bit.
// R15: Selection changes reach outputs by the cycle after the write; the registered outputs here change on the edge after the write loads the register.
module txsel_top
  import txsel_pkg::*;
#(
  parameter int TBUS_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic coder_env,
  input wire logic envelope_in_pin,
  input wire logic tx_stream,
  input wire logic card_mod,
  input wire logic rx_stream,
  input wire logic f_rx,
  input wire logic f_tx,
  input wire logic f_comp,
  input wire logic a_rx_car,
  input wire logic a_tx_car,
  input wire logic a_rx_raw,
  input wire logic a_env_raw,
  input wire logic [TBUS_W-1:0] test_bus,
  input wire logic [3:0] ext_test_sources,
  output logic ext_modulator_pin_out,
  output logic ext_modulator_pin_oe,
  output logic antenna_drive_a_out,
  output logic antenna_drive_a_oe,
  output logic antenna_drive_b_out,
  output logic antenna_drive_b_oe,
  output logic aux_signal_out_pin_out,
  output logic aux_signal_out_pin_oe
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] transmit_source_select_ff;
  logic [7:0] carrier_ctrl_ff;
  logic [7:0] test_select_reg_one_ff;
  logic [7:0] rdata_ff;
  logic [1:0] ext_modulator_source_sel;
  logic [1:0] antenna_driver_source_sel;
  logic [3:0] aux_output_source_sel;
  logic [2:0] test_bus_bit_pick;
  logic [1:0] ext_mod_test_pattern;
  logic ext_level;
  logic ext_mod_out_ff;
  logic ext_mod_oe_ff;

  assign ext_modulator_source_sel =
    transmit_source_select_ff[TXSEL_EXT_MOD_LSB +: 2];
  assign antenna_driver_source_sel =
    transmit_source_select_ff[TXSEL_DRV_LSB +: 2];
  assign aux_output_source_sel =
    transmit_source_select_ff[TXSEL_AUX_LSB +: 4];
  assign test_bus_bit_pick =
    test_select_reg_one_ff[TXSEL_TBUS_PICK_LSB +: 3];
  assign ext_mod_test_pattern =
    test_select_reg_one_ff[TXSEL_EXT_TEST_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transmit_source_select_ff <= TXSEL_SOURCE_SELECT_RST;
    end else if (reg_wr && reg_addr == TXSEL_ADDR_SOURCE_SELECT) begin
      transmit_source_select_ff <= reg_wdata; // R15
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      carrier_ctrl_ff <= TXSEL_CARRIER_CTRL_RST;
    end else if (reg_wr && reg_addr == TXSEL_ADDR_CARRIER_CTRL) begin
      carrier_ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      test_select_reg_one_ff <= TXSEL_TEST_SELECT_RST;
    end else if (reg_wr && reg_addr == TXSEL_ADDR_TEST_SELECT) begin
      test_select_reg_one_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data in the next cycle only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        TXSEL_ADDR_SOURCE_SELECT: rdata_ff <= transmit_source_select_ff;
        TXSEL_ADDR_CARRIER_CTRL: rdata_ff <= carrier_ctrl_ff;
        TXSEL_ADDR_TEST_SELECT: rdata_ff <= test_select_reg_one_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // External modulator pin
  always_comb begin
    case (ext_modulator_source_sel)
      2'b00: ext_level = 1'b0; // R1
      2'b01: ext_level = coder_env; // R1
      2'b10: ext_level = envelope_in_pin; // R1
      2'b11: ext_level = ext_test_sources[ext_mod_test_pattern]; // R1
      default: ext_level = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_mod_out_ff <= 1'b0;
      ext_mod_oe_ff <= 1'b0;
    end else begin
      ext_mod_out_ff <= ext_level; // R1 R15
      ext_mod_oe_ff <= (ext_modulator_source_sel != 2'b00); // R1
    end
  end

  assign ext_modulator_pin_out = ext_mod_out_ff;
  assign ext_modulator_pin_oe = ext_mod_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Antenna drivers
  txsel_drive_pin u_drive_a (
    .mclk(mclk),
    .rst(rst),
    .source_sel(antenna_driver_source_sel),
    .coder_env(coder_env),
    .ext_env(envelope_in_pin),
    .carrier_en(carrier_ctrl_ff[TXSEL_EN_A_BIT]),
    .inv_on(carrier_ctrl_ff[TXSEL_INV_A_ON_BIT]),
    .inv_off(carrier_ctrl_ff[TXSEL_INV_A_OFF_BIT]),
    .pin_out(antenna_drive_a_out),
    .pin_oe(antenna_drive_a_oe)
  );

  txsel_drive_pin u_drive_b (
    .mclk(mclk),
    .rst(rst),
    .source_sel(antenna_driver_source_sel),
    .coder_env(coder_env),
    .ext_env(envelope_in_pin),
    .carrier_en(carrier_ctrl_ff[TXSEL_EN_B_BIT]),
    .inv_on(carrier_ctrl_ff[TXSEL_INV_B_ON_BIT]),
    .inv_off(carrier_ctrl_ff[TXSEL_INV_B_OFF_BIT]),
    .pin_out(antenna_drive_b_out),
    .pin_oe(antenna_drive_b_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary signal output; receive-path codes rely on software (R8 R9 R11)
  txsel_aux_mux #(
    .TBUS_W(TBUS_W)
  ) u_aux (
    .mclk(mclk),
    .rst(rst),
    .source_sel(aux_output_source_sel),
    .test_bus(test_bus),
    .test_bus_bit_pick(test_bus_bit_pick),
    .coder_env(coder_env),
    .tx_stream(tx_stream),
    .card_mod(card_mod),
    .rx_stream(rx_stream),
    .f_rx(f_rx),
    .f_tx(f_tx),
    .f_comp(f_comp),
    .a_rx_car(a_rx_car),
    .a_tx_car(a_tx_car),
    .a_rx_raw(a_rx_raw),
    .a_env_raw(a_env_raw),
    .pin_out(aux_signal_out_pin_out),
    .pin_oe(aux_signal_out_pin_oe)
  );
endmodule
`default_nettype wire

// ---- test/txsel_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module txsel_sva
  import txsel_pkg::*;
#(
  parameter int TBUS_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic coder_env,
  input wire logic envelope_in_pin,
  input wire logic [TBUS_W-1:0] test_bus,
  input wire logic ext_modulator_pin_out,
  input wire logic ext_modulator_pin_oe,
  input wire logic antenna_drive_a_out,
  input wire logic antenna_drive_a_oe,
  input wire logic antenna_drive_b_oe,
  input wire logic aux_signal_out_pin_out,
  input wire logic aux_signal_out_pin_oe
);
  logic [7:0] sel_ff, car_ff, tst_ff;
  logic inv_a;
  assign inv_a = car_ff[0] ? car_ff[6] : car_ff[4];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_ff <= TXSEL_SOURCE_SELECT_RST;
      car_ff <= TXSEL_CARRIER_CTRL_RST;
      tst_ff <= TXSEL_TEST_SELECT_RST;
    end else if (reg_wr) begin
      if (reg_addr == TXSEL_ADDR_SOURCE_SELECT) sel_ff <= reg_wdata;
      if (reg_addr == TXSEL_ADDR_CARRIER_CTRL) car_ff <= reg_wdata;
      if (reg_addr == TXSEL_ADDR_TEST_SELECT) tst_ff <= reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_run;
    !$past(rst);
  endsequence
  sequence s_drv_off_wr;
    reg_wr && reg_addr == TXSEL_ADDR_SOURCE_SELECT && reg_wdata[5:4] == 2'h0;
  endsequence
  a_ext_mod_tri: assert property (s_run ##0
    $past(sel_ff[7:6]) == 2'h0 |-> !ext_modulator_pin_oe) else $error("ext");
  a_ext_mod_env: assert property (s_run ##0
    $past(sel_ff[7:6]) == 2'h2 |-> ext_modulator_pin_oe &&
    ext_modulator_pin_out == $past(envelope_in_pin)) else $error("env");
  a_drv_both_tri: assert property (s_run ##0
    $past(sel_ff[5:4]) == 2'h0 |-> !antenna_drive_a_oe && !antenna_drive_b_oe)
    else $error("drv tri");
  a_drv_coder_inv: assert property (s_run ##0
    $past(sel_ff[5:4]) == 2'h1 |->
    antenna_drive_a_out == ($past(coder_env) ^ $past(inv_a))) else $error("cod");
  a_drv_high_inv: assert property (s_run ##0
    $past(sel_ff[5:4]) == 2'h3 |-> antenna_drive_a_oe &&
    antenna_drive_a_out == !$past(inv_a)) else $error("high");
  a_aux_const_lvl: assert property (s_run ##0
    ($past(sel_ff[3:0]) == 4'h1 || $past(sel_ff[3:0]) == 4'h2) |->
    aux_signal_out_pin_oe &&
    aux_signal_out_pin_out == $past(sel_ff[1])) else $error("const");
  a_aux_tbus_bit: assert property (s_run ##0
    $past(sel_ff[3:0]) == 4'h3 |->
    aux_signal_out_pin_out == $past(test_bus[tst_ff[2:0]])) else $error("tbus");
  a_sel_latency: assert property (s_drv_off_wr |-> ##2
    !antenna_drive_a_oe && !antenna_drive_b_oe) else $error("late");
endmodule
bind txsel_top txsel_sva #(.TBUS_W(TBUS_W)) u_sva (.mclk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .coder_env, .envelope_in_pin, .test_bus,
  .ext_modulator_pin_out, .ext_modulator_pin_oe, .antenna_drive_a_out,
  .antenna_drive_a_oe, .antenna_drive_b_oe, .aux_signal_out_pin_out,
  .aux_signal_out_pin_oe);
`default_nettype wire

// ---- test/txsel_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
module txsel_far_side (
  input wire logic mclk,
  input wire logic slow,
  output logic [23:0] src
);
  int seed = 68;
  logic [1:0] cnt = 2'h0;
  initial src = 24'h0;
  // Receiver held in receive mode, rx lines always live
  always @(posedge mclk) begin
    cnt <= cnt + 2'h1;
    if (!slow || cnt == 2'h0) src <= 24'($random(seed));
  end
endmodule
`default_nettype wire

// ---- test/txsel_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module txsel_tb
  import txsel_pkg::*;
;
  logic mclk, rst, reg_wr, reg_rd, slow;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, m_sel, m_car, m_tst;
  logic [23:0] src;
  logic em_o, em_e, ta_o, ta_e, tb_o, tb_e, ax_o, ax_e;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 68;
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  txsel_far_side far (.mclk, .slow, .src);
  txsel_top #(.TBUS_W(8)) dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .coder_env(src[0]), .envelope_in_pin(src[1]),
    .tx_stream(src[2]), .card_mod(src[3]), .rx_stream(src[4]),
    .f_rx(src[5]), .f_tx(src[6]), .f_comp(src[7]), .a_rx_car(src[8]),
    .a_tx_car(src[9]), .a_rx_raw(src[10]), .a_env_raw(src[11]),
    .test_bus(src[19:12]), .ext_test_sources(src[23:20]),
    .ext_modulator_pin_out(em_o), .ext_modulator_pin_oe(em_e),
    .antenna_drive_a_out(ta_o), .antenna_drive_a_oe(ta_e),
    .antenna_drive_b_out(tb_o), .antenna_drive_b_oe(tb_e),
    .aux_signal_out_pin_out(ax_o), .aux_signal_out_pin_oe(ax_e));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] expect_now();
    logic [15:0] ax;
    logic [3:0] ev, dv;
    logic [7:0] rv;
    logic ia, ib, dr;
    ax = {src[11:8], 1'h0, src[7:2], src[0], src[12 + m_tst[2:0]], 3'h4};
    ev = {src[20 + m_tst[4:3]], src[1], src[0], 1'h0};
    dv = {1'h1, src[1], src[0], 1'h0};
    ia = m_car[0] ? m_car[6] : m_car[4];
    ib = m_car[1] ? m_car[7] : m_car[5];
    dr = m_sel[5:4] != 2'h0;
    rv = 8'h00;
    if (reg_rd && reg_addr == TXSEL_ADDR_SOURCE_SELECT) rv = m_sel;
    if (reg_rd && reg_addr == TXSEL_ADDR_CARRIER_CTRL) rv = m_car;
    if (reg_rd && reg_addr == TXSEL_ADDR_TEST_SELECT) rv = m_tst;
    return {rv, ev[m_sel[7:6]], m_sel[7:6] != 2'h0, dv[m_sel[5:4]] ^ ia,
      dr, dv[m_sel[5:4]] ^ ib, dr, ax[m_sel[3:0]], m_sel[3:0] != 4'h0};
  endfunction
  always @(posedge mclk) begin
    if (rst) begin
      m_sel <= TXSEL_SOURCE_SELECT_RST;
      m_car <= TXSEL_CARRIER_CTRL_RST;
      m_tst <= TXSEL_TEST_SELECT_RST;
    end else begin
      exp_q.push_back(expect_now());
      if (reg_wr && reg_addr == TXSEL_ADDR_SOURCE_SELECT) m_sel <= reg_wdata;
      if (reg_wr && reg_addr == TXSEL_ADDR_CARRIER_CTRL) m_car <= reg_wdata;
      if (reg_wr && reg_addr == TXSEL_ADDR_TEST_SELECT) m_tst <= reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp_pin(input logic [1:0] g, input logic [1:0] x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t pin got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t rdata got %h exp %h", $time, g, x);
    end
  endtask
  always @(negedge mclk) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!rst) begin
        cmp_pin({em_o, em_e}, e[7:6]);
        cmp_pin({ta_o, ta_e}, e[5:4]);
        cmp_pin({tb_o, tb_e}, e[3:2]);
        cmp_pin({ax_o, ax_e}, e[1:0]);
        cmp_rd(reg_rdata, e[15:8]);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'h1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    slow = 1'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    for (int a = 0; a < 6; a++) rd(4'(a));
    wr(4'h5, 8'hFF);
    rd(4'h5);
    // All codes swept, no type-A traffic in this bench
    for (int i = 0; i < 48; i++) begin
      if (i == 24) begin
        @(posedge mclk);
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        rd(TXSEL_ADDR_SOURCE_SELECT);
      end
      slow <= (i >= 16);
      wr(TXSEL_ADDR_CARRIER_CTRL, 8'($random(seed)));
      wr(TXSEL_ADDR_TEST_SELECT, 8'($random(seed)));
      wr(TXSEL_ADDR_SOURCE_SELECT, {i[1:0], i[3:2], i[3:0]});
      rd(TXSEL_ADDR_SOURCE_SELECT);
      repeat (4) @(posedge mclk);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
